/* rtl/pga_pkg.sv */
package pga_pkg;
  // register byte offsets
  localparam logic [7:0] REG_FLAGS = 8'h00;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_RISE_MASK = 8'h08;
  localparam logic [7:0] REG_FALL_MASK = 8'h0c;
  localparam logic [7:0] REG_EVT_MASK = 8'h10;
  localparam logic [7:0] REG_MON_CTRL = 8'h14;
  localparam logic [7:0] REG_SEL0 = 8'h18;
  localparam logic [7:0] REG_SEL1 = 8'h1c;
  localparam logic [7:0] REG_OUT_CTRL = 8'h20;
  localparam logic [7:0] REG_CMD = 8'h24;
  // source index: 0 stepdown0,1 stepdown1,2 stepup,3 supply,4 ext1,5 ext2,6 thermal warn
  localparam int NSRC = 7;
  localparam int SRC_STEPUP = 2;
  localparam int SRC_SUPPLY = 3;
  localparam int SRC_EXT1 = 4;
  localparam int SRC_EXT2 = 5;
  localparam int SRC_TWARN = 6;
  // flag bit positions in REG_FLAGS
  localparam int FLG_SRC_LO = 0;
  localparam int FLG_STEPUP_SUM = 7;
  localparam int FLG_DIAG_SUM = 8;
  localparam int FLG_CLK = 9;
  localparam int FLG_MEAS = 10;
  localparam int FLG_RESET = 11;
  localparam int NFLG = 12;
  // event mask positions in REG_EVT_MASK
  localparam int EM_CLK = 0;
  localparam int EM_MEAS = 1;
  localparam int EM_RESET = 2;
  // out ctrl bit positions
  localparam int OC_WINDOW = 0;
  localparam int OC_POL0 = 1;
  localparam int OC_POL1 = 2;
  localparam int OC_OD0 = 3;
  localparam int OC_OD1 = 4;
  localparam int OC_DLY0 = 5;
  localparam int OC_DLY1 = 6;
  localparam int CMD_SWRESET = 0;
  // reset values
  localparam logic [6:0] RST_MASK = 7'h00;
  localparam logic [6:0] RST_MON_EN = 7'h7f;
  localparam logic [6:0] RST_SEL = 7'h7f;
  localparam logic [6:0] RST_OUT_CTRL = 7'h06;
  localparam logic [2:0] RST_EVT_MASK = 3'h0;
  // rise delay
  localparam int CLK_HZ = 50_000_000;
  localparam int RISE_DELAY_MS = 11;
  localparam int RISE_DELAY_CYC = CLK_HZ / 1000 * RISE_DELAY_MS;
  localparam int DLY_W = 20;
endpackage

/* rtl/pga_out_if.sv */
`timescale 1ns/1ps
interface pga_out_if;
  logic ok;
  logic pol;
  logic od;
  logic force_def;
  logic pin_o;
  logic pin_oe;
  modport ctl (output ok, output pol, output od, output force_def, input pin_o, input pin_oe);
  modport drv (input ok, input pol, input od, input force_def, output pin_o, output pin_oe);
endinterface

/* rtl/pga_pin_drv.sv */
`timescale 1ns/1ps
module pga_pin_drv (
  input wire logic clk_in,
  input wire logic arst_n_in,
  pga_out_if.drv port_if
);
  logic level_r;
  wire asserted = port_if.ok & ~port_if.force_def;
  // default state is inactive level of the polarity
  wire level_nxt = asserted ? port_if.pol : ~port_if.pol;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      level_r <= 1'b0;
    end else begin
      level_r <= level_nxt;
    end
  end
  // open drain only pulls low
  assign port_if.pin_o = level_r;
  assign port_if.pin_oe = port_if.od ? ~level_r : 1'b1;
endmodule

/* rtl/pga_assert_dly.sv */
`timescale 1ns/1ps
module pga_assert_dly #(
  parameter int DELAY_CYC = pga_pkg::RISE_DELAY_CYC
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic good_in,
  input wire logic dly_en_in,
  output logic ok_out
);
  logic [pga_pkg::DLY_W-1:0] cnt_r;
  wire [pga_pkg::DLY_W-1:0] lim = pga_pkg::DLY_W'(DELAY_CYC - 1);
  wire done = cnt_r >= lim;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_r <= '0;
    end else if (!good_in) begin
      cnt_r <= '0;
    end else if (!done) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
  // deassert at once, assert after delay when enabled
  assign ok_out = good_in & (~dly_en_in | done);
  a_dly_wait: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    $rose(good_in) && dly_en_in |-> !ok_out) else $error("early assert");
endmodule

/* rtl/pga_top.sv */
`timescale 1ns/1ps
// Function
// - step-up good edges set step-up summary and flag, edge masks, write 1 clears
// - ext monitor 1 edges set diag summary and flag, state readable
// - ext monitor 2 edges set diag summary and flag, edge masks
// - supply monitor edges set diag summary and flag, edge masks
// - sync clock appear, vanish or absent sets maskable clock flag
// - measurement done sets maskable flag, no state bit, write 1 clears
// - undervoltage resets all registers, no flag raised
// - start-up or software reset sets maskable reset flag
// - sources chosen independently for irq pin and both outputs
// - only voltage monitored; per-source enable bits
// - disabled converter is masked from outputs and interrupts
// - window bit 0 checks undervoltage only, 1 also overvoltage
// - monitoring interrupts combine onto irq pin via masks
// - per-output select bits pick sources, separately for each output
// - each output has polarity and open-drain bits
// - output asserted only while all selected sources are in tolerance
// - rise delay bit waits 11 ms before asserting
// - thermal shutdown or overvoltage forces outputs to default
// - gated or continuous mode fixed by factory strap
// - irq pin low while any source flag or unmasked event flag set
module pga_top #(
  parameter int RISE_DELAY_CYC = pga_pkg::RISE_DELAY_CYC
) (
  input wire logic CLK_SYS_IN,
  input wire logic ARST_N_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic [6:0] UNDER_OK_IN,
  input wire logic [6:0] OVER_OK_IN,
  input wire logic [2:0] CONV_ENABLED_IN,
  input wire logic SYNC_CLK_EVENT_IN,
  input wire logic MEAS_DONE_IN,
  input wire logic UVLO_IN,
  input wire logic THERMAL_SD_IN,
  input wire logic SUPPLY_OVP_IN,
  input wire logic CONT_MODE_STRAP_IN,
  output logic IRQ_N_OUT,
  output logic POWER_OK_OUT_0,
  output logic POWER_OK_OE_OUT_0,
  output logic POWER_OK_OUT_1,
  output logic POWER_OK_OE_OUT_1,
  output logic CONT_MODE_OUT
);
  localparam int N = pga_pkg::NSRC;
  // pin inputs cross two flops
  logic [N-1:0] uv_s1_r, uv_s2_r, ov_s1_r, ov_s2_r;
  logic [2:0] en_s1_r, en_s2_r;
  logic [4:0] ev_s1_r, ev_s2_r, ev_d_r;
  logic uvlo_s1_r, uvlo_s2_r;
  // monitors start at the good level so release gives no false edge
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      uv_s1_r <= '1;
      uv_s2_r <= '1;
      ov_s1_r <= '1;
      ov_s2_r <= '1;
      en_s1_r <= '0;
      en_s2_r <= '0;
      ev_s1_r <= '0;
      ev_s2_r <= '0;
      ev_d_r <= '0;
      uvlo_s1_r <= 1'b0;
      uvlo_s2_r <= 1'b0;
    end else begin
      uv_s1_r <= UNDER_OK_IN;
      uv_s2_r <= uv_s1_r;
      ov_s1_r <= OVER_OK_IN;
      ov_s2_r <= ov_s1_r;
      en_s1_r <= CONV_ENABLED_IN;
      en_s2_r <= en_s1_r;
      ev_s1_r <= {SUPPLY_OVP_IN, THERMAL_SD_IN, CONT_MODE_STRAP_IN, MEAS_DONE_IN,
                  SYNC_CLK_EVENT_IN};
      ev_s2_r <= ev_s1_r;
      ev_d_r <= ev_s2_r;
      uvlo_s1_r <= UVLO_IN;
      uvlo_s2_r <= uvlo_s1_r;
    end
  end
  wire clk_ev = ev_s2_r[0] & ~ev_d_r[0];
  wire meas_ev = ev_s2_r[1] & ~ev_d_r[1];
  wire fault_force = ev_s2_r[3] | ev_s2_r[4];

  // software registers
  logic [6:0] rise_mask_r, fall_mask_r, mon_en_r, sel0_r, sel1_r, out_ctrl_r;
  logic [2:0] evt_mask_r;
  logic [pga_pkg::NFLG-1:0] flags_r, flags_nxt;
  logic [N-1:0] good_d_r;
  logic init_r, swreset_r, cont_mode_r, strap_done_r;
  logic [1:0] strap_wait_r;

  // ahb-lite slave, zero wait states
  logic wr_pend_r, rd_pend_r;
  logic [7:0] addr_r;
  wire take = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
  wire do_wr = wr_pend_r;
  wire [31:0] wd = HWDATA_IN;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction
  wire wr_flags = do_wr & hit(addr_r, pga_pkg::REG_FLAGS);
  wire wr_cmd = do_wr & hit(addr_r, pga_pkg::REG_CMD);
  wire sw_reset = wr_cmd & wd[pga_pkg::CMD_SWRESET];

  // monitor evaluation
  wire [N-1:0] conv_en = {4'hf, en_s2_r};
  wire win = out_ctrl_r[pga_pkg::OC_WINDOW];
  wire [N-1:0] good_now = uv_s2_r & (win ? ov_s2_r : {N{1'b1}});
  wire [N-1:0] active = mon_en_r & conv_en;
  wire [N-1:0] good_eff = good_now | ~active;
  wire [N-1:0] rose = active & good_now & ~good_d_r;
  wire [N-1:0] fell = active & ~good_now & good_d_r;
  wire [N-1:0] src_hit = (rose & ~rise_mask_r) | (fell & ~fall_mask_r);
  wire diag_hit = src_hit[pga_pkg::SRC_SUPPLY] | src_hit[pga_pkg::SRC_EXT1] |
    src_hit[pga_pkg::SRC_EXT2];
  wire [pga_pkg::NFLG-1:0] set_vec = {
    init_r | swreset_r,
    meas_ev,
    clk_ev,
    diag_hit,
    src_hit[pga_pkg::SRC_STEPUP],
    src_hit};
  wire [pga_pkg::NFLG-1:0] clr_vec = wr_flags ? wd[pga_pkg::NFLG-1:0] : '0;
  // set beats clear in the same cycle
  assign flags_nxt = (flags_r & ~clr_vec) | set_vec;

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= '0;
    end else begin
      wr_pend_r <= take & HWRITE_IN;
      rd_pend_r <= take & ~HWRITE_IN;
      if (take) begin
        addr_r <= HADDR_IN[7:0];
      end
    end
  end

  // undervoltage or software reset returns all control registers to defaults
  wire soft_clr = uvlo_s2_r | sw_reset;
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rise_mask_r <= pga_pkg::RST_MASK;
      fall_mask_r <= pga_pkg::RST_MASK;
      evt_mask_r <= pga_pkg::RST_EVT_MASK;
      mon_en_r <= pga_pkg::RST_MON_EN;
      sel0_r <= pga_pkg::RST_SEL;
      sel1_r <= pga_pkg::RST_SEL;
      out_ctrl_r <= pga_pkg::RST_OUT_CTRL;
    end else if (soft_clr) begin
      rise_mask_r <= pga_pkg::RST_MASK;
      fall_mask_r <= pga_pkg::RST_MASK;
      evt_mask_r <= pga_pkg::RST_EVT_MASK;
      mon_en_r <= pga_pkg::RST_MON_EN;
      sel0_r <= pga_pkg::RST_SEL;
      sel1_r <= pga_pkg::RST_SEL;
      out_ctrl_r <= pga_pkg::RST_OUT_CTRL;
    end else if (do_wr) begin
      if (hit(addr_r, pga_pkg::REG_RISE_MASK)) rise_mask_r <= wd[6:0];
      if (hit(addr_r, pga_pkg::REG_FALL_MASK)) fall_mask_r <= wd[6:0];
      if (hit(addr_r, pga_pkg::REG_EVT_MASK)) evt_mask_r <= wd[2:0];
      if (hit(addr_r, pga_pkg::REG_MON_CTRL)) mon_en_r <= wd[6:0];
      if (hit(addr_r, pga_pkg::REG_SEL0)) sel0_r <= wd[6:0];
      if (hit(addr_r, pga_pkg::REG_SEL1)) sel1_r <= wd[6:0];
      if (hit(addr_r, pga_pkg::REG_OUT_CTRL)) out_ctrl_r <= wd[6:0];
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      flags_r <= '0;
      good_d_r <= '1;
      strap_wait_r <= '0;
      init_r <= 1'b1;
      swreset_r <= 1'b0;
      strap_done_r <= 1'b0;
      cont_mode_r <= 1'b0;
    end else begin
      // uvlo clears flags without raising one
      flags_r <= uvlo_s2_r ? '0 : flags_nxt;
      good_d_r <= good_now;
      init_r <= uvlo_s2_r; // start-up after supply returns
      swreset_r <= sw_reset;
      // factory mode caught once, after the synchroniser has filled
      strap_wait_r <= {strap_wait_r[0], 1'b1};
      strap_done_r <= strap_wait_r[1];
      if (strap_wait_r[1] && !strap_done_r) cont_mode_r <= ev_s2_r[2];
    end
  end
  assign CONT_MODE_OUT = cont_mode_r;

  // irq pin: any source flag plus unmasked event flags
  wire [2:0] evt_flags = {flags_r[pga_pkg::FLG_RESET], flags_r[pga_pkg::FLG_MEAS],
    flags_r[pga_pkg::FLG_CLK]};
  wire irq_any = (|flags_r[N-1:0]) | (|(evt_flags & ~evt_mask_r));
  assign IRQ_N_OUT = ~irq_any;

  // power-good outputs
  wire [N-1:0] sel_good0 = good_eff | ~sel0_r;
  wire [N-1:0] sel_good1 = good_eff | ~sel1_r;
  wire all_good0 = &sel_good0;
  wire all_good1 = &sel_good1;
  logic ok0, ok1;
  pga_assert_dly #(.DELAY_CYC(RISE_DELAY_CYC)) u_dly0 (
    .clk_in(CLK_SYS_IN),
    .arst_n_in(ARST_N_IN),
    .good_in(all_good0),
    .dly_en_in(out_ctrl_r[pga_pkg::OC_DLY0]),
    .ok_out(ok0)
  );
  pga_assert_dly #(.DELAY_CYC(RISE_DELAY_CYC)) u_dly1 (
    .clk_in(CLK_SYS_IN),
    .arst_n_in(ARST_N_IN),
    .good_in(all_good1),
    .dly_en_in(out_ctrl_r[pga_pkg::OC_DLY1]),
    .ok_out(ok1)
  );
  pga_out_if o0 ();
  pga_out_if o1 ();
  assign o0.ok = ok0;
  assign o0.pol = out_ctrl_r[pga_pkg::OC_POL0];
  assign o0.od = out_ctrl_r[pga_pkg::OC_OD0];
  assign o0.force_def = fault_force;
  assign o1.ok = ok1;
  assign o1.pol = out_ctrl_r[pga_pkg::OC_POL1];
  assign o1.od = out_ctrl_r[pga_pkg::OC_OD1];
  assign o1.force_def = fault_force;
  pga_pin_drv u_pin0 (.clk_in(CLK_SYS_IN), .arst_n_in(ARST_N_IN), .port_if(o0));
  pga_pin_drv u_pin1 (.clk_in(CLK_SYS_IN), .arst_n_in(ARST_N_IN), .port_if(o1));
  assign POWER_OK_OUT_0 = o0.pin_o;
  assign POWER_OK_OE_OUT_0 = o0.pin_oe;
  assign POWER_OK_OUT_1 = o1.pin_o;
  assign POWER_OK_OE_OUT_1 = o1.pin_oe;

  // read mux, unmapped reads zero
  logic [31:0] rdata;
  always_comb begin
    rdata = '0;
    case (addr_r)
      pga_pkg::REG_FLAGS: rdata[pga_pkg::NFLG-1:0] = flags_r;
      pga_pkg::REG_STATE: rdata[N-1:0] = good_now;
      pga_pkg::REG_RISE_MASK: rdata[6:0] = rise_mask_r;
      pga_pkg::REG_FALL_MASK: rdata[6:0] = fall_mask_r;
      pga_pkg::REG_EVT_MASK: rdata[2:0] = evt_mask_r;
      pga_pkg::REG_MON_CTRL: rdata[6:0] = mon_en_r;
      pga_pkg::REG_SEL0: rdata[6:0] = sel0_r;
      pga_pkg::REG_SEL1: rdata[6:0] = sel1_r;
      pga_pkg::REG_OUT_CTRL: rdata[7:0] = {cont_mode_r, out_ctrl_r};
      default: rdata = '0;
    endcase
  end
  assign HRDATA_OUT = rd_pend_r ? rdata : '0;

  a_flag_sets: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    src_hit[pga_pkg::SRC_STEPUP] && !uvlo_s2_r |=> flags_r[pga_pkg::FLG_STEPUP_SUM])
    else $error("stepup flag missed");
  a_diag_sum: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    diag_hit && !uvlo_s2_r |=> flags_r[pga_pkg::FLG_DIAG_SUM])
    else $error("diag flag missed");
  a_irq_level: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    (|flags_r[N-1:0]) |-> !IRQ_N_OUT) else $error("irq not low");
  a_uvlo_clear: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    uvlo_s2_r |=> flags_r == '0 && mon_en_r == pga_pkg::RST_MON_EN)
    else $error("uvlo clear failed");
  a_force_def: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    fault_force && o0.pol |=> !POWER_OK_OUT_0) else $error("pg0 not forced");
  a_good_drop: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    !all_good0 && !fault_force |=> POWER_OK_OUT_0 == !$past(o0.pol))
    else $error("pg0 not dropped");
  a_swreset_flag: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    sw_reset && !uvlo_s2_r ##1 !uvlo_s2_r |=> flags_r[pga_pkg::FLG_RESET])
    else $error("reset flag missed");
  a_dis_masked: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    !en_s2_r[0] |-> !src_hit[0]) else $error("disabled converter hit");
  c_irq: cover property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN) $fell(IRQ_N_OUT));
  c_clear: cover property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN) $rose(IRQ_N_OUT));
  c_pg_rise: cover property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN) $rose(ok0));
endmodule

/* testbench/pga_host_model.sv */
`timescale 1ns/1ps
module pga_host_model (
  input wire logic clk_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  output logic [31:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [31:0] hwdata_out
);
  initial begin
    haddr_out = 32'h0;
    htrans_out = 2'b00;
    hwrite_out = 1'b0;
    hwdata_out = 32'h0;
  end
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_in);
    haddr_out <= {24'h0, a};
    htrans_out <= 2'b10;
    hwrite_out <= w;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    htrans_out <= 2'b00;
    hwdata_out <= d;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    q = hrdata_in;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(a, 1'b0, 32'h0, q);
  endtask
  // write back exactly what was seen, so a late event is not lost
  task automatic svc();
    logic [31:0] f;
    xfer(pga_pkg::REG_FLAGS, 1'b0, 32'h0, f);
    xfer(pga_pkg::REG_FLAGS, 1'b1, f, f);
  endtask
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic [6:0] u; logic [31:0] f;} pga_row_type;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [6:0] under = 7'h7f;
  logic [6:0] over = 7'h7f;
  logic [2:0] conv = 3'h7;
  logic [1:0] ev = 2'b00;
  logic uvlo = 1'b0;
  logic tsd = 1'b0;
  logic ovp = 1'b0;
  logic strap = 1'b0;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic hwrite, hready, hresp, irq_n, pok0, poe0, pok1, poe1, cont;
  int n_mismatch = 0;
  int checks_done = 0;
  pga_row_type rows [7] = '{'{7'h7e, 32'h001}, '{7'h7d, 32'h002}, '{7'h7b, 32'h084},
    '{7'h77, 32'h108}, '{7'h6f, 32'h110}, '{7'h5f, 32'h120}, '{7'h3f, 32'h040}};
  // open-drain line assumed pulled up when released
  wire pg1_line = poe1 ? pok1 : 1'b1;
  always #10 clk = ~clk;
  pga_top #(.RISE_DELAY_CYC(20)) u_pga_top (.CLK_SYS_IN(clk), .ARST_N_IN(arst_n),
    .HSEL_IN(1'b1), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(3'b010), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .UNDER_OK_IN(under), .OVER_OK_IN(over),
    .CONV_ENABLED_IN(conv), .SYNC_CLK_EVENT_IN(ev[0]), .MEAS_DONE_IN(ev[1]),
    .UVLO_IN(uvlo), .THERMAL_SD_IN(tsd), .SUPPLY_OVP_IN(ovp), .CONT_MODE_STRAP_IN(strap),
    .IRQ_N_OUT(irq_n), .POWER_OK_OUT_0(pok0), .POWER_OK_OE_OUT_0(poe0),
    .POWER_OK_OUT_1(pok1), .POWER_OK_OE_OUT_1(poe1), .CONT_MODE_OUT(cont));
  pga_host_model u_pga_host_model (.clk_in(clk), .hready_in(hready), .hrdata_in(hrdata),
    .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hwdata_out(hwdata));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    u_pga_host_model.rd(a, rv);
    chk(nm, e, rv);
  endtask
  task automatic pins(input logic [2:0] e, input string nm);
    cyc(1);
    chk(nm, {29'h0, e}, {29'h0, irq_n, pok0, pok1});
  endtask
  task automatic drv(input logic [6:0] u, input logic [6:0] o);
    @(posedge clk);
    under <= u;
    over <= o;
    cyc(8);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_pga_host_model.wr(a, d);
  endtask
  task automatic svc();
    u_pga_host_model.svc();
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #(20 * 20000);
    n_mismatch++;
    finish_test();
  end
  initial begin
    cyc(10);
    arst_n <= 1'b1;
    cyc(10);
    rdc(pga_pkg::REG_FLAGS, 32'h800, "flags_at_reset");
    pins(3'b011, "pins_at_reset");
    rdc(pga_pkg::REG_MON_CTRL, 32'h7f, "mon_enable");
    rdc(pga_pkg::REG_SEL0, 32'h7f, "select0");
    rdc(pga_pkg::REG_SEL1, 32'h7f, "select1");
    rdc(pga_pkg::REG_OUT_CTRL, 32'h06, "out_ctrl");
    rdc(8'h40, 32'h0, "unmapped");
    chk("mode", 32'h0, {31'h0, cont});
    wr(pga_pkg::REG_FLAGS, 32'hfff);
    rdc(pga_pkg::REG_FLAGS, 32'h0, "flags_cleared");
    pins(3'b111, "pins_idle");
    foreach (rows[i]) begin
      drv(rows[i].u, 7'h7f);
      rdc(pga_pkg::REG_FLAGS, rows[i].f, "flags_fall");
      rdc(pga_pkg::REG_STATE, {25'h0, rows[i].u}, "state");
      pins(3'b000, "pins_fall");
      wr(pga_pkg::REG_FLAGS, rows[i].f);
      drv(7'h7f, 7'h7f);
      rdc(pga_pkg::REG_FLAGS, rows[i].f, "flags_rise");
      pins(3'b011, "pins_rise");
      svc();
      pins(3'b111, "pins_serviced");
    end
    wr(pga_pkg::REG_RISE_MASK, 32'h04);
    drv(7'h7b, 7'h7f);
    rdc(pga_pkg::REG_FLAGS, 32'h084, "fall_unmasked");
    svc();
    drv(7'h7f, 7'h7f);
    rdc(pga_pkg::REG_FLAGS, 32'h0, "rise_masked");
    wr(pga_pkg::REG_FALL_MASK, 32'h04);
    drv(7'h7b, 7'h7f);
    rdc(pga_pkg::REG_FLAGS, 32'h0, "fall_masked");
    pins(3'b100, "pins_masked");
    drv(7'h7f, 7'h7f);
    wr(pga_pkg::REG_RISE_MASK, 32'h0);
    wr(pga_pkg::REG_FALL_MASK, 32'h0);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) wr(pga_pkg::REG_EVT_MASK, 32'h3);
      @(posedge clk);
      ev <= (i == 2) ? 2'b11 : 2'b01 << i;
      cyc(3);
      ev <= 2'b00;
      cyc(8);
      if (i < 2) rdc(pga_pkg::REG_FLAGS, 32'h200 << i, "event_flag");
      pins({i == 2, 2'b11}, "event_pins");
      svc();
    end
    wr(pga_pkg::REG_EVT_MASK, 32'h0);
    drv(7'h7f, 7'h77);
    rdc(pga_pkg::REG_FLAGS, 32'h0, "window0");
    wr(pga_pkg::REG_OUT_CTRL, 32'h07);
    cyc(8);
    rdc(pga_pkg::REG_FLAGS, 32'h108, "window1");
    pins(3'b000, "window1_pins");
    drv(7'h7f, 7'h7f);
    wr(pga_pkg::REG_OUT_CTRL, 32'h06);
    svc();
    wr(pga_pkg::REG_SEL0, 32'h0);
    wr(pga_pkg::REG_MON_CTRL, 32'h5f);
    @(posedge clk);
    conv <= 3'b011;
    drv(7'h4b, 7'h7f);
    rdc(pga_pkg::REG_FLAGS, 32'h110, "enabled_only");
    pins(3'b010, "select_pins");
    drv(7'h7f, 7'h7f);
    conv <= 3'b111;
    wr(pga_pkg::REG_SEL0, 32'h7f);
    wr(pga_pkg::REG_MON_CTRL, 32'h7f);
    svc();
    wr(pga_pkg::REG_OUT_CTRL, 32'h14);
    cyc(6);
    chk("pol_od_good", 32'h6, {28'h0, pok0, poe0, pg1_line, poe1});
    drv(7'h77, 7'h7f);
    chk("pol_od_bad", 32'hd, {28'h0, pok0, poe0, pg1_line, poe1});
    drv(7'h7f, 7'h7f);
    wr(pga_pkg::REG_OUT_CTRL, 32'h06);
    svc();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      {ovp, tsd} <= 2'b01 << i;
      cyc(8);
      chk("forced", 32'h0, {30'h0, pok0, pok1});
      @(posedge clk);
      {ovp, tsd} <= 2'b00;
      cyc(8);
      chk("released", 32'h3, {30'h0, pok0, pok1});
    end
    svc();
    wr(pga_pkg::REG_OUT_CTRL, 32'h26);
    drv(7'h77, 7'h7f);
    drv(7'h7f, 7'h7f);
    chk("delay_wait", 32'h1, {30'h0, pok0, pok1});
    cyc(30);
    chk("delay_done", 32'h3, {30'h0, pok0, pok1});
    svc();
    wr(pga_pkg::REG_CMD, 32'h1);
    cyc(8);
    rdc(pga_pkg::REG_OUT_CTRL, 32'h06, "swreset_ctrl");
    rdc(pga_pkg::REG_FLAGS, 32'h800, "swreset_flag");
    svc();
    wr(pga_pkg::REG_OUT_CTRL, 32'h07);
    @(posedge clk);
    uvlo <= 1'b1;
    cyc(8);
    rdc(pga_pkg::REG_FLAGS, 32'h0, "uvlo_flags");
    rdc(pga_pkg::REG_OUT_CTRL, 32'h06, "uvlo_ctrl");
    chk("uvlo_irq", 32'h1, {31'h0, irq_n});
    uvlo <= 1'b0;
    cyc(8);
    rdc(pga_pkg::REG_FLAGS, 32'h800, "startup_flag");
    strap <= 1'b1;
    arst_n <= 1'b0;
    cyc(10);
    arst_n <= 1'b1;
    cyc(6);
    chk("mode_strap", 32'h1, {31'h0, cont});
    rdc(pga_pkg::REG_OUT_CTRL, 32'h86, "out_ctrl_mode");
    rdc(pga_pkg::REG_FLAGS, 32'h800, "flags_rereset");
    finish_test();
  end
endmodule
